/* File: hdl/ppi_map.svh */
// Constants for the printer/plotter programmed-I/O port
`ifndef PPI_MAP_SVH
`define PPI_MAP_SVH
// ------------------------------------------------------------
// Transfer codes (octal 6657, 6661-6667)
// ------------------------------------------------------------
`define PPI_IOT_LOAD_CMD   12'h0DAF
`define PPI_IOT_SKIP_FLAG  12'h0DB1
`define PPI_IOT_CLR_FLAG   12'h0DB2
`define PPI_IOT_SKIP_FAULT 12'h0DB3
`define PPI_IOT_LOAD_BYTE  12'h0DB4
`define PPI_IOT_INT_ON     12'h0DB5
`define PPI_IOT_CLR_LOAD   12'h0DB6
`define PPI_IOT_INT_OFF    12'h0DB7
// ------------------------------------------------------------
// Accumulator positions (bit 11 is the vector's bit 0)
// ------------------------------------------------------------
`define PPI_AC_MODE     0
`define PPI_AC_MODE_EN  1
`define PPI_AC_FF       2
`define PPI_AC_EOT      3
`define PPI_AC_CLEAR    4
`define PPI_AC_LTERM    5
`define PPI_CMD_W       6
`define PPI_BYTE_W      8
// Printer command pulse vector
`define PPI_P_FF        0
`define PPI_P_EOT       1
`define PPI_P_CLEAR     2
`define PPI_P_LTERM     3
`define PPI_P_LF        4
`define PPI_P_W         5
// ------------------------------------------------------------
// Character codes
// ------------------------------------------------------------
`define PPI_CH_CR  8'h0D
`define PPI_CH_LF  8'h0A
`define PPI_CH_FF  8'h0C
`define PPI_CH_EOT 8'h04
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PPI_CLK_NS     8
`define PPI_STROBE_NS  500
`define PPI_STROBE_CYC ((`PPI_STROBE_NS + `PPI_CLK_NS - 1) / `PPI_CLK_NS)
`define PPI_TONER_MS   1500
`define PPI_TONER_CYC  ((`PPI_TONER_MS * 1000000) / `PPI_CLK_NS)
`define PPI_CNT_W      28
`define PPI_PULSE_W    8
`define PPI_LINE_CHARS 132
`define PPI_CHAR_W     8
`endif

/* File: hdl/ppi_pkg.sv */
// Types for the printer/plotter programmed-I/O port
`include "ppi_map.svh"
package ppi_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STROBE,
    ST_WAIT_READY,
    ST_HOLD
  } ppi_state_type;

  // Processor transfer request
  typedef struct packed {
    logic        valid;
    logic [11:0] code;
    logic [11:0] acc;
  } ppi_iot_type;

  // Lines toward the printer
  typedef struct packed {
    logic [`PPI_BYTE_W-1:0] data;
    logic                   strobe;
    logic                   plot_mode;
    logic [`PPI_P_W-1:0]    cmd;
  } ppi_prn_type;

  typedef struct packed {
    logic [`PPI_CMD_W-1:0]   cmd;
    logic                    accept;
    logic                    int_en;
    logic [`PPI_BYTE_W-1:0]  data;
    ppi_state_type           st;
    logic [`PPI_PULSE_W-1:0] stb_cnt;
    logic [`PPI_PULSE_W-1:0] cmd_cnt;
    logic [`PPI_P_W-1:0]     pulses;
    logic                    rdy_m;
    logic                    rdy_s;
    logic                    ok_m;
    logic                    ok_s;
    logic [`PPI_CNT_W-1:0]   idle_cnt;
    logic [`PPI_CNT_W-1:0]   hold_cnt;
    logic [`PPI_CHAR_W-1:0]  char_cnt;
    logic                    suppress;
  } ppi_regs_type;
endpackage : ppi_pkg

/* File: hdl/ppi_port.sv */
// Printer/plotter port: transfer decode, command register, accept flag
`timescale 1ns/1ps
`include "ppi_map.svh"
module ppi_port #(
  parameter int unsigned TONER_CYC  = `PPI_TONER_CYC,
  parameter int unsigned LINE_CHARS = `PPI_LINE_CHARS
) (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            srst,
  // Processor transfer path
  input  wire ppi_pkg::ppi_iot_type io_transfer_instruction,
  output logic                 skip,
  output logic                 irq,
  output logic                 accept_flag,
  // Printer side
  output ppi_pkg::ppi_prn_type prn,
  input  wire logic            prn_ready_n,
  input  wire logic            prn_online
);

  ppi_pkg::ppi_regs_type r_r;
  ppi_pkg::ppi_regs_type r_nxt;

  localparam logic [`PPI_CNT_W-1:0] TONER_LIM = TONER_CYC[`PPI_CNT_W-1:0];
  // Strobe length rounded up so the pulse is never shorter than asked
  localparam int unsigned STB_INT = `PPI_STROBE_CYC;
  localparam logic [`PPI_PULSE_W-1:0] STB_CYC =
    STB_INT[`PPI_PULSE_W-1:0];
  localparam logic [`PPI_CHAR_W-1:0] LINE_LIM = LINE_CHARS[`PPI_CHAR_W-1:0];

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic is_code(input ppi_pkg::ppi_iot_type t,
                                   input logic [11:0] c);
    is_code = t.valid && (t.code == c);
  endfunction : is_code

  function automatic logic is_format(input logic [7:0] b);
    is_format = (b == `PPI_CH_CR) || (b == `PPI_CH_LF) ||
                (b == `PPI_CH_FF) || (b == `PPI_CH_EOT);
  endfunction : is_format

  logic do_cmd;
  logic do_load;
  logic do_clr;
  logic set_acc;
  logic prints;
  logic drop;
  logic [7:0] byte_in;
  logic [`PPI_CHAR_W-1:0] cnt_inc;

  assign do_cmd  = is_code(io_transfer_instruction, `PPI_IOT_LOAD_CMD);
  // combined code both loads and clears
  assign do_load = is_code(io_transfer_instruction, `PPI_IOT_LOAD_BYTE) ||
                   is_code(io_transfer_instruction, `PPI_IOT_CLR_LOAD);
  assign do_clr  = is_code(io_transfer_instruction, `PPI_IOT_CLR_FLAG) ||
                   is_code(io_transfer_instruction, `PPI_IOT_CLR_LOAD);
  assign byte_in = io_transfer_instruction.acc[`PPI_BYTE_W-1:0];
  assign cnt_inc = r_r.char_cnt + 1'b1;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    r_nxt   = r_r;
    set_acc = 1'b0;
    prints  = 1'b0;
    drop    = 1'b0;
    r_nxt.rdy_m = prn_ready_n;
    r_nxt.rdy_s = r_r.rdy_m;
    r_nxt.ok_m  = prn_online;
    r_nxt.ok_s  = r_r.ok_m;

    if (r_r.idle_cnt != TONER_LIM) begin
      r_nxt.idle_cnt = r_r.idle_cnt + 1'b1;
    end
    if (r_r.cmd_cnt != '0) begin
      r_nxt.cmd_cnt = r_r.cmd_cnt - 1'b1;
    end else begin
      r_nxt.pulses = '0;
    end

    case (r_r.st)
      ppi_pkg::ST_IDLE: begin
        r_nxt.st = ppi_pkg::ST_IDLE;
      end
      ppi_pkg::ST_STROBE: begin
        r_nxt.stb_cnt = r_r.stb_cnt - 1'b1;
        if (r_r.stb_cnt == 1) begin
          r_nxt.st = ppi_pkg::ST_WAIT_READY;
        end
      end
      ppi_pkg::ST_WAIT_READY: begin
        // printer drops ready when it can take more
        if (!r_r.rdy_s) begin
          if (r_r.hold_cnt != '0) begin
            r_nxt.st = ppi_pkg::ST_HOLD;
          end else begin
            set_acc  = 1'b1;
            r_nxt.st = ppi_pkg::ST_IDLE;
          end
        end
      end
      ppi_pkg::ST_HOLD: begin
        // extra wait for the toner pump
        r_nxt.hold_cnt = r_r.hold_cnt - 1'b1;
        if (r_r.hold_cnt == 1) begin
          set_acc  = 1'b1;
          r_nxt.st = ppi_pkg::ST_IDLE;
        end
      end
      default: begin
        r_nxt.st = ppi_pkg::ST_IDLE;
      end
    endcase

    if (do_cmd) begin
      r_nxt.cmd[`PPI_CMD_W-1:1] = io_transfer_instruction.acc[`PPI_CMD_W-1:1];
      // mode changes only with enable set
      if (io_transfer_instruction.acc[`PPI_AC_MODE_EN]) begin
        r_nxt.cmd[`PPI_AC_MODE] = io_transfer_instruction.acc[`PPI_AC_MODE];
      end
      r_nxt.pulses[`PPI_P_FF]  = io_transfer_instruction.acc[`PPI_AC_FF] &&
                                 r_nxt.cmd[`PPI_AC_MODE];
      // end of transmission, plot mode only
      r_nxt.pulses[`PPI_P_EOT] = io_transfer_instruction.acc[`PPI_AC_EOT] &&
                                 r_nxt.cmd[`PPI_AC_MODE];
      r_nxt.pulses[`PPI_P_CLEAR] = io_transfer_instruction.acc[`PPI_AC_CLEAR];
      // not when print mode, nor when this load writes plot
      r_nxt.pulses[`PPI_P_LTERM] = io_transfer_instruction.acc[`PPI_AC_LTERM] &&
        r_r.cmd[`PPI_AC_MODE] &&
        !(io_transfer_instruction.acc[`PPI_AC_MODE_EN] && io_transfer_instruction.acc[`PPI_AC_MODE]);
      r_nxt.pulses[`PPI_P_LF] = 1'b0;
      r_nxt.cmd_cnt = STB_CYC;
      prints = r_nxt.pulses[`PPI_P_FF] || r_nxt.pulses[`PPI_P_EOT] ||
               r_nxt.pulses[`PPI_P_LTERM];
      if (io_transfer_instruction.acc[`PPI_AC_CLEAR]) begin
        r_nxt.char_cnt = '0;
        r_nxt.suppress = 1'b0;
      end
    end

    // clear comes before the set below, so a set wins
    if (do_clr) begin
      r_nxt.accept = 1'b0;
    end

    if (do_load) begin
      r_nxt.data = byte_in;
      if (!r_r.cmd[`PPI_AC_MODE]) begin
        // drop first CR/LF after a full-buffer print
        if (r_r.suppress && ((byte_in == `PPI_CH_CR) ||
                             (byte_in == `PPI_CH_LF))) begin
          drop           = 1'b1;
          set_acc        = 1'b1;
          r_nxt.suppress = (byte_in == `PPI_CH_CR);
        end else if (is_format(byte_in)) begin
          // format codes print, so flag waits on printer
          prints         = 1'b1;
          r_nxt.suppress = 1'b0;
          r_nxt.char_cnt = '0;
          // CR with buffered text also feeds a line
          if ((byte_in == `PPI_CH_CR) && (r_r.char_cnt != '0)) begin
            r_nxt.pulses[`PPI_P_LF] = 1'b1;
            r_nxt.cmd_cnt = STB_CYC;
          end
          // EOT byte is passed for the long advance
        end else if (cnt_inc == LINE_LIM) begin
          prints         = 1'b1;
          r_nxt.suppress = 1'b1;
          r_nxt.char_cnt = '0;
        end else begin
          r_nxt.suppress = 1'b0;
          r_nxt.char_cnt = cnt_inc;
        end
      end
      if (!drop) begin
        r_nxt.st      = ppi_pkg::ST_STROBE;
        r_nxt.stb_cnt = STB_CYC;
        r_nxt.hold_cnt = '0;
      end
    end

    if (prints) begin
      if (r_r.idle_cnt == TONER_LIM) begin
        r_nxt.hold_cnt = TONER_LIM;
      end
      r_nxt.idle_cnt = '0;
    end

    if (set_acc) begin
      r_nxt.accept = 1'b1;
    end

    if (is_code(io_transfer_instruction, `PPI_IOT_INT_ON)) begin
      r_nxt.int_en = 1'b1;
    end
    if (is_code(io_transfer_instruction, `PPI_IOT_INT_OFF)) begin
      r_nxt.int_en = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      // command register starts in print mode
      r_r       <= '0;
      r_r.rdy_m <= 1'b1;
      r_r.rdy_s <= 1'b1;
      r_r.st    <= ppi_pkg::ST_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // skip while the flag is set; skip on printer fault
  assign skip = (is_code(io_transfer_instruction, `PPI_IOT_SKIP_FLAG) && r_r.accept) ||
                (is_code(io_transfer_instruction, `PPI_IOT_SKIP_FAULT) && !r_r.ok_s);
  // request held while enabled and flag set
  assign irq         = r_r.int_en && r_r.accept;
  assign accept_flag = r_r.accept;
  assign prn.data    = r_r.data;
  assign prn.strobe  = (r_r.st == ppi_pkg::ST_STROBE);
  // mode line follows the register at once; the printer keeps
  // a started cycle in its old mode, so no ready check is needed
  assign prn.plot_mode = r_r.cmd[`PPI_AC_MODE];
  assign prn.cmd       = r_r.pulses;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence load_seq;
    do_load && !drop;
  endsequence
  sequence strobe_seq;
    prn.strobe [*8];
  endsequence

  irq_gate_a: assert property (irq == (r_r.int_en && accept_flag))
    else $error("irq does not follow enable and flag");
  flag_clear_a: assert property (do_clr && !set_acc |=> !accept_flag)
    else $error("accept flag survived a clear");
  flag_skip_a: assert property (
    is_code(io_transfer_instruction, `PPI_IOT_SKIP_FLAG) |-> (skip == accept_flag))
    else $error("flag skip wrong");
  int_on_a: assert property (
    is_code(io_transfer_instruction, `PPI_IOT_INT_ON) && !is_code(io_transfer_instruction, `PPI_IOT_INT_OFF)
    |=> r_r.int_en)
    else $error("interrupt enable not set");
  mode_keep_a: assert property (
    do_cmd && !io_transfer_instruction.acc[`PPI_AC_MODE_EN] |=> $stable(prn.plot_mode))
    else $error("mode changed without enable");
  mode_load_a: assert property (
    do_cmd && io_transfer_instruction.acc[`PPI_AC_MODE_EN]
    |=> prn.plot_mode == $past(io_transfer_instruction.acc[`PPI_AC_MODE]))
    else $error("mode not loaded");
  lterm_block_a: assert property (
    do_cmd && io_transfer_instruction.acc[`PPI_AC_MODE_EN] && io_transfer_instruction.acc[`PPI_AC_MODE]
    && !r_r.cmd[`PPI_AC_MODE] |=> !prn.cmd[`PPI_P_LTERM])
    else $error("line terminate on mode write");
  data_load_a: assert property (
    load_seq |=> (prn.data == $past(byte_in)) ##0 strobe_seq)
    else $error("byte not presented with strobe");
  // Loads and prints restart the hold, so only an undisturbed hold is judged
  toner_hold_a: assert property (
    r_r.st == ppi_pkg::ST_HOLD && !accept_flag && !do_load && !do_cmd &&
    r_r.hold_cnt != 1 |=> !accept_flag &&
    (r_r.hold_cnt < $past(r_r.hold_cnt)))
    else $error("toner hold not counting");
  ready_flag_a: assert property (
    r_r.st == ppi_pkg::ST_WAIT_READY && !r_r.rdy_s && r_r.hold_cnt == '0
    |=> accept_flag || $past(do_clr) || $past(do_load))
    else $error("flag not raised on ready");

  // ------------------------------------------------------------
  // Checks on pulses, skips, interrupts, reset and dropped format codes
  // ------------------------------------------------------------
  // A dropped CR/LF answers at once and starts no strobe, though prn.data still takes the byte
  sequence dropped_seq;
    accept_flag && !prn.strobe;
  endsequence
  sequence buffered_cr_seq;
    do_load && !drop && !r_r.cmd[`PPI_AC_MODE] &&
    (byte_in == `PPI_CH_CR) && (r_r.char_cnt != '0);
  endsequence

  int_off_a: assert property (
    is_code(io_transfer_instruction, `PPI_IOT_INT_OFF) |=> !irq)
    else $error("interrupt request survived disable");
  skip_idle_a: assert property (
    !io_transfer_instruction.valid |-> !skip)
    else $error("skip without a transfer");
  // Status line passes two flops, so the skip sees it two edges late
  fault_skip_a: assert property (
    is_code(io_transfer_instruction, `PPI_IOT_SKIP_FAULT) && !$past(prn_online, 2)
    |-> skip)
    else $error("fault skip missing");
  ff_gate_a: assert property (
    do_cmd && !io_transfer_instruction.acc[`PPI_AC_MODE_EN] && !prn.plot_mode
    |=> !prn.cmd[`PPI_P_FF] && !prn.cmd[`PPI_P_EOT])
    else $error("form feed or end pulse in print mode");
  eot_pulse_a: assert property (
    do_cmd && !io_transfer_instruction.acc[`PPI_AC_MODE_EN] && prn.plot_mode &&
    io_transfer_instruction.acc[`PPI_AC_EOT] |=> prn.cmd[`PPI_P_EOT])
    else $error("end of transmission pulse missing");
  clear_pulse_a: assert property (
    do_cmd && io_transfer_instruction.acc[`PPI_AC_CLEAR] |=> prn.cmd[`PPI_P_CLEAR])
    else $error("buffer clear pulse missing");
  drop_print_a: assert property (
    do_load && drop && r_r.st == ppi_pkg::ST_IDLE |=> dropped_seq)
    else $error("dropped format code reached the printer");
  lf_pulse_a: assert property (
    buffered_cr_seq |=> prn.cmd[`PPI_P_LF])
    else $error("no line feed after buffered CR");
  strobe_end_a: assert property (
    r_r.st == ppi_pkg::ST_STROBE && r_r.stb_cnt == 1 && !do_load
    |=> !prn.strobe)
    else $error("strobe longer than its count");
  combo_load_a: assert property (
    is_code(io_transfer_instruction, `PPI_IOT_CLR_LOAD) && !drop && r_r.st == ppi_pkg::ST_IDLE
    |=> prn.strobe && !accept_flag)
    else $error("combined code did not clear and load");
  reset_print_a: assert property (disable iff (1'b0)
    srst |=> !prn.plot_mode && !accept_flag && !prn.strobe)
    else $error("reset did not return to print mode");

endmodule : ppi_port

/* File: test/ppi_printer_model.sv */
// Behavioural printer model that answers the port's data strobe
`timescale 1ns/1ps
module ppi_printer_model #(
  parameter int unsigned DLY = 4
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // Port side
  input  wire logic strobe,
  input  wire logic slow,
  output logic      ready_n
);
  // ------------------------------------------------------------
  // Ready handshake
  // ------------------------------------------------------------
  int unsigned cnt;

  always @(posedge sys_clk) begin
    if (srst) begin
      ready_n <= 1'b0;
      cnt     <= 0;
    end else if (strobe) begin
      ready_n <= 1'b1;
      cnt     <= slow ? 4 * DLY : DLY;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end else begin
      ready_n <= 1'b0;
    end
  end
endmodule : ppi_printer_model

/* File: test/ppi_port_tb.sv */
// Self-checking testbench for the printer/plotter port
`timescale 1ns/1ps
`include "ppi_map.svh"
module ppi_port_tb;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic                 sys_clk;
  logic                 srst;
  ppi_pkg::ppi_iot_type io_transfer_instruction;
  logic                 skip;
  logic                 irq;
  logic                 accept_flag;
  ppi_pkg::ppi_prn_type prn;
  logic                 prn_ready_n;
  logic                 prn_online;
  logic                 slow;
  int                   n_fail;
  int                   check_count;

  // Short toner hold and short line keep the run brief
  ppi_port #(.TONER_CYC(50), .LINE_CHARS(4)) uut (
    .sys_clk(sys_clk), .srst(srst), .io_transfer_instruction(io_transfer_instruction), .skip(skip), .irq(irq),
    .accept_flag(accept_flag), .prn(prn), .prn_ready_n(prn_ready_n),
    .prn_online(prn_online));

  ppi_printer_model prt (
    .sys_clk(sys_clk), .srst(srst), .strobe(prn.strobe), .slow(slow),
    .ready_n(prn_ready_n));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Skip is combinational, so it is sampled inside the request cycle
  task automatic op(input logic [11:0] c, input logic [11:0] a,
                    output logic sk);
    @(posedge sys_clk);
    io_transfer_instruction.code  <= c;
    io_transfer_instruction.acc   <= a;
    io_transfer_instruction.valid <= 1'b1;
    @(negedge sys_clk);
    sk = skip;
    @(posedge sys_clk);
    io_transfer_instruction.valid <= 1'b0;
    @(negedge sys_clk);
  endtask : op

  task automatic wait_flag(input int lim, output int n);
    n = 0;
    while (accept_flag !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_flag

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk("flag", 8'h00, {7'h0, accept_flag});
    chk("plot", 8'h00, {7'h0, prn.plot_mode});
    chk("irq", 8'h00, {7'h0, irq});
  endtask : t_reset

  task automatic t_byte;
    logic sk;
    int   n;
    op(`PPI_IOT_INT_ON, 12'h000, sk);
    op(`PPI_IOT_LOAD_BYTE, 12'hF41, sk);
    chk("data", 8'h41, prn.data);
    chk("strobe", 8'h01, {7'h0, prn.strobe});
    wait_flag(125, n);
    chk("flag_fast", 8'h01, {7'h0, accept_flag});
    chk("irq", 8'h01, {7'h0, irq});
    op(`PPI_IOT_INT_OFF, 12'h000, sk);
    chk("irq_off", 8'h00, {7'h0, irq});
    @(posedge sys_clk);
    slow <= 1'b1;
    op(`PPI_IOT_CLR_LOAD, 12'h0C2, sk);
    chk("flag_clr", 8'h00, {7'h0, accept_flag});
    chk("data", 8'hC2, prn.data);
    wait_flag(200, n);
    chk("flag_slow", 8'h01, {7'h0, accept_flag});
    @(posedge sys_clk);
    slow <= 1'b0;
  endtask : t_byte

  task automatic t_skip;
    logic sk;
    op(`PPI_IOT_SKIP_FLAG, 12'h000, sk);
    chk("skip_set", 8'h01, {7'h0, sk});
    op(`PPI_IOT_CLR_FLAG, 12'h000, sk);
    chk("flag", 8'h00, {7'h0, accept_flag});
    op(`PPI_IOT_SKIP_FLAG, 12'h000, sk);
    chk("skip_clr", 8'h00, {7'h0, sk});
  endtask : t_skip

  task automatic t_fault;
    logic sk;
    @(posedge sys_clk);
    prn_online <= 1'b0;
    repeat (4) @(negedge sys_clk);
    op(`PPI_IOT_SKIP_FAULT, 12'h000, sk);
    chk("skip_fault", 8'h01, {7'h0, sk});
    @(posedge sys_clk);
    prn_online <= 1'b1;
    repeat (4) @(negedge sys_clk);
    op(`PPI_IOT_SKIP_FAULT, 12'h000, sk);
    chk("skip_ok", 8'h00, {7'h0, sk});
  endtask : t_fault

  task automatic t_cmd;
    logic [11:0] a[9] = '{12'h003, 12'h004, 12'h008, 12'h020, 12'h002,
                          12'h004, 12'h030, 12'h023, 12'h002};
    logic [7:0]  p[9] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00,
                          8'h00, 8'h00, 8'h01, 8'h00};
    logic [7:0]  c[9] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h00,
                          8'h00, 8'h04, 8'h00, 8'h00};
    logic        sk;
    for (int i = 0; i < 9; i++) begin
      op(`PPI_IOT_LOAD_CMD, a[i], sk);
      chk("plot", p[i], {7'h0, prn.plot_mode});
      chk("cmd", c[i], {3'h0, prn.cmd});
      repeat (70) @(negedge sys_clk);
    end
  endtask : t_cmd

  task automatic t_crlf;
    logic sk;
    int   n;
    op(`PPI_IOT_CLR_LOAD, 12'h041, sk);
    wait_flag(125, n);
    op(`PPI_IOT_CLR_LOAD, {4'h0, `PPI_CH_CR}, sk);
    chk("cmd_lf", 8'h10, {3'h0, prn.cmd});
    wait_flag(200, n);
    chk("flag_cr", 8'h01, {7'h0, accept_flag});
  endtask : t_crlf

  task automatic t_toner;
    logic sk;
    int   n;
    repeat (80) @(negedge sys_clk);
    op(`PPI_IOT_CLR_LOAD, {4'h0, `PPI_CH_CR}, sk);
    repeat (90) @(negedge sys_clk);
    chk("flag_held", 8'h00, {7'h0, accept_flag});
    wait_flag(200, n);
    chk("flag_late", 8'h01, {7'h0, accept_flag});
  endtask : t_toner

  // Full line arms suppression of the next CR/LF pair
  task automatic t_full;
    logic sk;
    int   n;
    op(`PPI_IOT_LOAD_CMD, 12'h010, sk);
    chk("cmd_clr", 8'h04, {3'h0, prn.cmd});
    for (int i = 0; i < 4; i++) begin
      op(`PPI_IOT_CLR_LOAD, 12'h041, sk);
      wait_flag(200, n);
    end
    op(`PPI_IOT_CLR_LOAD, {4'h0, `PPI_CH_CR}, sk);
    chk("cr_drop", 8'h00, {7'h0, prn.strobe});
    chk("cr_flag", 8'h01, {7'h0, accept_flag});
    op(`PPI_IOT_CLR_LOAD, {4'h0, `PPI_CH_LF}, sk);
    chk("lf_drop", 8'h00, {7'h0, prn.strobe});
    op(`PPI_IOT_CLR_LOAD, {4'h0, `PPI_CH_CR}, sk);
    chk("cr_print", 8'h01, {7'h0, prn.strobe});
    wait_flag(200, n);
    chk("flag_cr2", 8'h01, {7'h0, accept_flag});
  endtask : t_full

  // Reset in mid-run returns to print mode with the flag clear
  task automatic t_rerun;
    logic sk;
    op(`PPI_IOT_LOAD_CMD, 12'h003, sk);
    op(`PPI_IOT_INT_ON, 12'h000, sk);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    chk("plot_rst", 8'h00, {7'h0, prn.plot_mode});
    chk("flag_rst", 8'h00, {7'h0, accept_flag});
    chk("irq_rst", 8'h00, {7'h0, irq});
    op(`PPI_IOT_LOAD_CMD, 12'h003, sk);
    chk("plot_again", 8'h01, {7'h0, prn.plot_mode});
  endtask : t_rerun

  // ------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    srst        = 1'b1;
    io_transfer_instruction         = '0;
    prn_online  = 1'b1;
    slow        = 1'b0;
    n_fail      = 0;
    check_count = 0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    t_reset();
    t_byte();
    t_skip();
    t_fault();
    t_cmd();
    t_crlf();
    t_toner();
    t_full();
    t_rerun();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end
endmodule : ppi_port_tb
